// file: hw/cfp_flash_port.sv
// cfp_flash_port: parallel and serial programming port of the code flash
// assumes all pins asynchronous to clk_i; wishbone master on clk_i
//
// Functional notes
// - code array spans 0000h to 2fffh, one contiguous range
// - serial byte write erases the location itself first
// - parallel write has no auto-erase; only ones become zeros
// - one write strobe pulse starts a self-timed 1.5 ms write
// - read modes put the addressed byte on the data port
// - during a write, reads return the written byte, bit 7 inverted
// - polling allowed any time; true data once the write ends
// - progress pin low after strobe rises, high when write done
// - code verify only while lock bits one and two unprogrammed
// - lock bits readable in parallel mode, never over serial
// - strobe low 10 ms in erase mode sets the array to ones
// - serial chip erase is self-timed, about 16 ms, array to ones
// - serial reads during chip erase return 00h
// - serial-enable fuse blocks serial mode; set in parallel only
// - signature bytes read at 030h and 031h with c, d low
// - serial program and erase ignored until enable received
// - serial write programs one byte, self-timed, 2.5 ms bound
// - serial read shifts the addressed byte out on miso
// - reset pin low ends programming mode
// - every serial instruction is exactly three bytes
// - enable is ac then 53, third byte ignored
// - chip erase is ac then low bits 100
// - address: six msbs of byte one, low byte two; data byte three
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
module cfp_flash_port #(
	parameter int         PWRITE_CYC = cfp_pkg::PWRITE_CYC,
	parameter int         SWRITE_CYC = cfp_pkg::SWRITE_CYC,
	parameter int         SERASE_CYC = cfp_pkg::SERASE_CYC,
	parameter int         PULSE_CYC  = cfp_pkg::PULSE_CYC,
	// signature values: arbitrary
	parameter logic [7:0] SIG0_VAL   = 8'h5a,
	parameter logic [7:0] SIG1_VAL   = 8'ha5
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// parallel pins
	input  wire logic        prog_reset_i,
	input  wire logic        store_enable_pin_n_i,
	input  wire logic        high_voltage_enable_pin_i,
	input  wire logic        write_strobe_n_i,
	input  wire logic        mode_select_a_i,
	input  wire logic        mode_select_b_i,
	input  wire logic        mode_select_c_i,
	input  wire logic        mode_select_d_i,
	input  wire logic [13:0] addr_i,
	input  wire logic [7:0]  data_port_i,
	output logic      [7:0]  data_port_o,
	output logic             data_port_oe_o,
	output logic             progress_indicator_pin_o,
	// serial pins
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	output logic             miso_o
);
	localparam logic [23:0] PW_LIM = 24'(PWRITE_CYC);
	localparam logic [23:0] SW_LIM = 24'(SWRITE_CYC);
	localparam logic [23:0] SE_LIM = 24'(SERASE_CYC);
	localparam logic [23:0] PL_LIM = 24'(PULSE_CYC);

	cfp_pkg::cfp_pins_type  pin_raw, pin_s1, pin_s2, pin_q;
	cfp_pkg::cfp_state_type state;
	cfp_pkg::cfp_instr_type ser_word;
	logic        ctl_enable, prog_en, fuse_serial;
	logic [2:0]  lock;
	logic [23:0] op_cnt, op_lim, pulse_cnt, ser_sr;
	logic [13:0] wr_addr, sweep, mem_addr, ser_addr, ser_wr_addr;
	logic [7:0]  wr_data, mem_rdata, mem_wdata, par_rd, ser_rd, out_sr;
	logic [4:0]  ser_cnt;
	logic [31:0] status;
	logic        wr_par, wr_lock, sweep_done, mem_we, op_done, idle;
	logic        par_active, ser_mode, strobe_rise, sck_rise, sck_fall;
	logic        pulse_hit, ser_done, is_key, rd_mode, wb_hit;
	logic        start_erase, start_pw, start_pl, start_sw;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	assign pin_raw = '{prog_reset: prog_reset_i,
		store_n: store_enable_pin_n_i, hv: high_voltage_enable_pin_i,
		strobe_n: write_strobe_n_i, sck: sck_i, mosi: mosi_i,
		mode: {mode_select_a_i, mode_select_b_i,
			mode_select_c_i, mode_select_d_i},
		addr: addr_i, data: data_port_i};

	// third stage only feeds edge detection
	always_ff @(posedge clk_i) begin
		pin_s1 <= pin_raw;
		pin_s2 <= pin_s1;
		pin_q  <= pin_s2;
	end

	// ****************************************************************
	// mode and event decode
	// ****************************************************************
	assign idle        = state == cfp_pkg::ST_IDLE;
	assign par_active  = ctl_enable & pin_s2.prog_reset & ~pin_s2.store_n
		& pin_s2.hv;
	assign ser_mode    = ctl_enable & pin_s2.prog_reset & pin_s2.store_n
		& fuse_serial;
	assign strobe_rise = par_active & pin_s2.strobe_n & ~pin_q.strobe_n;
	// sck far slower than clk_i, so edges are found by sampling
	assign sck_rise    = ser_mode & pin_s2.sck & ~pin_q.sck;
	assign sck_fall    = ser_mode & ~pin_s2.sck & pin_q.sck;
	assign pulse_hit   = par_active & ~pin_s2.strobe_n
		& (pulse_cnt == PL_LIM - 24'd1);
	assign ser_done    = sck_rise & (ser_cnt == cfp_pkg::SER_LAST);
	assign ser_word    = {ser_sr[22:0], pin_s2.mosi};
	assign is_key      = ser_word.b0 == cfp_pkg::SER_KEY;
	assign ser_addr    = {ser_sr[15:10], ser_sr[7:0]};
	assign ser_wr_addr = {ser_word.b0[7:2], ser_word.b1};
	assign rd_mode     = pin_s2.mode inside {cfp_pkg::MODE_READ,
		cfp_pkg::MODE_RLOCK, cfp_pkg::MODE_SIG, cfp_pkg::MODE_RFUSE};

	assign start_erase = idle & ((pulse_hit
		& pin_s2.mode == cfp_pkg::MODE_ERASE)
		| (ser_done & prog_en & is_key
		& ser_word.b1[2:0] == cfp_pkg::SER_ERASE));
	assign start_pw = idle & strobe_rise & ~lock[0]
		& pin_s2.mode == cfp_pkg::MODE_WRITE
		& cfp_pkg::cfp_in_range(pin_s2.addr);
	assign start_pl = idle & strobe_rise
		& pin_s2.mode == cfp_pkg::MODE_WLOCK;
	assign start_sw = idle & ser_done & prog_en & ~is_key & ~lock[0]
		& ser_word.b0[1:0] == cfp_pkg::OP_WRITE
		& cfp_pkg::cfp_in_range(ser_wr_addr);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= cfp_pkg::ST_IDLE;
		end else begin
			unique case (state)
				cfp_pkg::ST_IDLE: begin
					if (start_erase) begin
						state <= cfp_pkg::ST_WIPE;
					end else if (start_pw | start_pl | start_sw) begin
						state <= cfp_pkg::ST_WRITE;
					end
				end
				cfp_pkg::ST_WRITE: begin
					if (op_done) begin
						state <= cfp_pkg::ST_IDLE;
					end
				end
				cfp_pkg::ST_WIPE: begin
					if (op_done & sweep_done) begin
						state <= cfp_pkg::ST_IDLE;
					end
				end
				default: state <= cfp_pkg::ST_IDLE;
			endcase
		end
	end

	// self-timed operation length
	assign op_done = op_cnt >= op_lim - 24'd1;
	always_ff @(posedge clk_i) begin
		if (rst_i || idle) begin
			op_cnt <= 24'd0;
		end else if (!op_done) begin
			op_cnt <= op_cnt + 24'd1;
		end
	end

	// parallel erase already took its 10 ms in the strobe pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_lim  <= PW_LIM;
			wr_addr <= cfp_pkg::ADDR_LO;
			wr_data <= cfp_pkg::ERASED;
			wr_par  <= 1'b0;
			wr_lock <= 1'b0;
		end else if (start_erase) begin
			op_lim <= ser_done ? SE_LIM : 24'd1;
		end else if (start_pw | start_pl) begin
			op_lim  <= PW_LIM;
			wr_addr <= pin_s2.addr;
			wr_data <= pin_s2.data;
			wr_par  <= 1'b1;
			wr_lock <= start_pl;
		end else if (start_sw) begin
			op_lim  <= SW_LIM;
			wr_addr <= ser_wr_addr;
			wr_data <= ser_word.b2;
			wr_par  <= 1'b0;
			wr_lock <= 1'b0;
		end
	end

	// erase sweep; one location per cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || state != cfp_pkg::ST_WIPE) begin
			sweep      <= cfp_pkg::ADDR_LO;
			sweep_done <= 1'b0;
		end else if (!sweep_done) begin
			if (sweep == cfp_pkg::ADDR_HI) begin
				sweep_done <= 1'b1;
			end else begin
				sweep <= sweep + 14'd1;
			end
		end
	end

	// ****************************************************************
	// array access
	// ****************************************************************
	always_comb begin
		mem_we    = 1'b0;
		mem_wdata = wr_data;
		mem_addr  = pin_s2.addr;
		if (state == cfp_pkg::ST_WIPE) begin
			mem_addr  = sweep;
			mem_we    = ~sweep_done;
			mem_wdata = cfp_pkg::ERASED;
		end else if (state == cfp_pkg::ST_WRITE) begin
			mem_addr = wr_addr;
			mem_we   = op_done & ~wr_lock;
			if (wr_par) begin
				mem_wdata = mem_rdata & wr_data;
			end
		end else if (ser_mode) begin
			mem_addr = ser_addr;
		end
	end

	cfp_code_mem u_mem (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.addr_i  (mem_addr),
		.wdata_i (mem_wdata),
		.rdata_o (mem_rdata)
	);

	// ****************************************************************
	// lock bits and serial fuse
	// ****************************************************************
	// fuse returns to enabled on core reset; no real nonvolatile cell
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock        <= 3'b000;
			fuse_serial <= cfp_pkg::FUSE_RST;
		end else begin
			if (start_erase) begin
				lock <= 3'b000;
			end else if (state == cfp_pkg::ST_WRITE && op_done && wr_lock) begin
				lock <= lock | ~{wr_data[5], wr_data[6], wr_data[7]};
			end
			if (idle && pulse_hit && pin_s2.mode == cfp_pkg::MODE_FUSE) begin
				fuse_serial <= ~pin_s2.data[0];
			end
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	function automatic logic [7:0] code_byte(input logic [13:0] a);
		if (state == cfp_pkg::ST_WIPE) begin
			return cfp_pkg::BLANK_RD;
		end else if (state == cfp_pkg::ST_WRITE) begin
			return {~wr_data[7], wr_data[6:0]};
		end else if (lock[0] || lock[1] || !cfp_pkg::cfp_in_range(a)) begin
			return cfp_pkg::BLANK_RD;
		end
		return mem_rdata;
	endfunction

	always_comb begin
		unique case (pin_s2.mode)
			cfp_pkg::MODE_READ:  par_rd = code_byte(pin_s2.addr);
			cfp_pkg::MODE_RLOCK: begin
				par_rd = {5'h00, lock[0], lock[1], lock[2]};
			end
			cfp_pkg::MODE_SIG: begin
				if (pin_s2.addr == cfp_pkg::SIG0_ADR) begin
					par_rd = SIG0_VAL;
				end else if (pin_s2.addr == cfp_pkg::SIG1_ADR) begin
					par_rd = SIG1_VAL;
				end else begin
					par_rd = cfp_pkg::BLANK_RD;
				end
			end
			cfp_pkg::MODE_RFUSE: par_rd = {7'h00, ~fuse_serial};
			default: par_rd = cfp_pkg::BLANK_RD;
		endcase
	end

	// serial path has no lock read at all
	always_comb begin
		ser_rd = code_byte(ser_addr);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_port_o <= cfp_pkg::BLANK_RD;
		end else begin
			data_port_o <= par_rd;
		end
	end

	assign data_port_oe_o = par_active & pin_s2.strobe_n & rd_mode;
	assign progress_indicator_pin_o =
		~(state == cfp_pkg::ST_WRITE & wr_par);

	// parallel strobe length for erase and fuse
	always_ff @(posedge clk_i) begin
		if (rst_i || !par_active || pin_s2.strobe_n) begin
			pulse_cnt <= 24'd0;
		end else if (pulse_cnt != PL_LIM) begin
			pulse_cnt <= pulse_cnt + 24'd1;
		end
	end

	// ****************************************************************
	// serial shifter
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i || !ser_mode) begin
			ser_cnt <= 5'd0;
			ser_sr  <= 24'h000000;
		end else if (sck_rise) begin
			ser_sr  <= ser_word;
			ser_cnt <= ser_done ? 5'd0 : ser_cnt + 5'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !pin_s2.prog_reset) begin
			prog_en <= 1'b0;
		end else if (ser_done && is_key
			&& ser_word.b1 == cfp_pkg::SER_ENABLE) begin
			prog_en <= 1'b1;
		end
	end

	// third byte goes out msb first
	always_ff @(posedge clk_i) begin
		if (rst_i || !ser_mode) begin
			out_sr <= 8'h00;
			miso_o <= 1'b0;
		end else if (sck_fall) begin
			if (ser_cnt == cfp_pkg::SER_BYTE3) begin
				out_sr <= ser_rd;
				miso_o <= ser_rd[7];
			end else begin
				out_sr <= {out_sr[6:0], 1'b0};
				miso_o <= out_sr[6];
			end
		end
	end

	// ****************************************************************
	// wishbone registers
	// ****************************************************************
	assign wb_hit = wb_cyc_i & wb_stb_i;
	always_comb begin
		status = 32'h00000000;
		status[cfp_pkg::ST_BUSY]  = ~idle;
		status[cfp_pkg::ST_ERASE] = state == cfp_pkg::ST_WIPE;
		status[cfp_pkg::ST_SEREN] = prog_en;
		status[cfp_pkg::ST_FUSE]  = fuse_serial;
		status[cfp_pkg::ST_LOCK +: 3] = lock;
		status[cfp_pkg::ST_PAR]   = par_active;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_hit & ~wb_ack_o;
			unique case (wb_adr_i)
				cfp_pkg::REG_CTRL:   wb_dat_o <= {31'h0, ctl_enable};
				cfp_pkg::REG_STATUS: wb_dat_o <= status;
				cfp_pkg::REG_LAST:   wb_dat_o <= {18'h0, wr_addr};
				default:             wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_enable <= cfp_pkg::CTRL_RST;
		end else if (wb_hit && wb_ack_o && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == cfp_pkg::REG_CTRL) begin
			ctl_enable <= wb_dat_i[0];
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_erase_zero;
		state == cfp_pkg::ST_WIPE && sck_fall
			&& ser_cnt == cfp_pkg::SER_BYTE3 |=> !miso_o;
	endproperty
	a_erase_zero: assert property (p_erase_zero)
		else $error("serial read during erase not zero");

	property p_busy_low;
		start_pw |=> !progress_indicator_pin_o [*3];
	endproperty
	a_busy_low: assert property (p_busy_low)
		else $error("progress pin not low after write strobe");

	property p_write_held;
		state == cfp_pkg::ST_WRITE && op_cnt < op_lim - 24'd1
			|=> state == cfp_pkg::ST_WRITE;
	endproperty
	a_write_held: assert property (p_write_held)
		else $error("write ended before its time");

	property p_no_prog_before_enable;
		ser_done && !prog_en |=> state == cfp_pkg::ST_IDLE;
	endproperty
	a_no_prog_before_enable: assert property (p_no_prog_before_enable)
		else $error("serial operation ran without enable");

	property p_enable_cmd;
		ser_done && is_key && ser_word.b1 == cfp_pkg::SER_ENABLE
			&& pin_s2.prog_reset |=> prog_en;
	endproperty
	a_enable_cmd: assert property (p_enable_cmd)
		else $error("enable instruction not taken");

	property p_lock_verify;
		idle && par_active && pin_s2.mode == cfp_pkg::MODE_READ
			&& (lock[0] || lock[1]) |=> data_port_o == 8'h00;
	endproperty
	a_lock_verify: assert property (p_lock_verify)
		else $error("verify allowed under lock");

	property p_poll;
		state == cfp_pkg::ST_WRITE && $stable(state)
			&& pin_s2.mode == cfp_pkg::MODE_READ
			|=> data_port_o[7] != wr_data[7];
	endproperty
	a_poll: assert property (p_poll)
		else $error("polling bit not inverted");

	property p_in_range;
		mem_we |-> mem_addr <= cfp_pkg::ADDR_HI;
	endproperty
	a_in_range: assert property (p_in_range)
		else $error("array write outside code range");

	property p_reset_exit;
		!pin_s2.prog_reset |=> !prog_en ##1 !prog_en;
	endproperty
	a_reset_exit: assert property (p_reset_exit)
		else $error("programming mode kept after reset low");

	c_ser_write: cover property (start_sw);
	c_ser_erase: cover property (start_erase && ser_done);
	c_par_write: cover property (start_pw ##1 state == cfp_pkg::ST_WRITE);
	c_par_erase: cover property (start_erase && !ser_done);
endmodule

// file: hw/cfp_pkg.sv
// cfp_pkg: constants and types of the code flash programming port
// assumes a 200 MHz core clock; the CYC counts below are in core cycles
package cfp_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ     = 200;
	localparam int T_PWRITE_US = 1500;
	localparam int T_SWRITE_US = 2500;
	localparam int T_SERASE_US = 16000;
	localparam int T_PULSE_US  = 10000;
	localparam int PWRITE_CYC  = T_PWRITE_US * CLK_MHZ;
	localparam int SWRITE_CYC  = T_SWRITE_US * CLK_MHZ;
	localparam int SERASE_CYC  = T_SERASE_US * CLK_MHZ;
	localparam int PULSE_CYC   = T_PULSE_US * CLK_MHZ;
	// ****************************************************************
	// code array
	// ****************************************************************
	localparam logic [13:0] ADDR_LO  = 14'h0000;
	localparam logic [13:0] ADDR_HI  = 14'h2fff;
	localparam logic [13:0] DEPTH    = 14'h3000;
	localparam logic [7:0]  ERASED   = 8'hff;
	localparam logic [7:0]  BLANK_RD = 8'h00;
	localparam logic [13:0] SIG0_ADR = 14'h0030;
	localparam logic [13:0] SIG1_ADR = 14'h0031;
	localparam logic        FUSE_RST = 1'b1;
	// ****************************************************************
	// parallel modes, {a,b,c,d}
	// ****************************************************************
	localparam logic [3:0] MODE_ERASE = 4'h8;
	localparam logic [3:0] MODE_WRITE = 4'h7;
	localparam logic [3:0] MODE_READ  = 4'h3;
	localparam logic [3:0] MODE_WLOCK = 4'ha;
	localparam logic [3:0] MODE_RLOCK = 4'hc;
	localparam logic [3:0] MODE_SIG   = 4'h0;
	localparam logic [3:0] MODE_FUSE  = 4'h5;
	localparam logic [3:0] MODE_RFUSE = 4'hd;
	// ****************************************************************
	// serial instructions
	// ****************************************************************
	localparam logic [7:0] SER_KEY    = 8'hac;
	localparam logic [7:0] SER_ENABLE = 8'h53;
	localparam logic [2:0] SER_ERASE  = 3'h4;
	localparam logic [1:0] OP_READ    = 2'h1;
	localparam logic [1:0] OP_WRITE   = 2'h2;
	localparam logic [4:0] SER_LAST   = 5'd23;
	localparam logic [4:0] SER_BYTE3  = 5'd16;
	// ****************************************************************
	// register bus
	// ****************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LAST   = 8'h08;
	localparam logic       CTRL_RST   = 1'b1;
	localparam int ST_BUSY  = 0;
	localparam int ST_ERASE = 1;
	localparam int ST_SEREN = 2;
	localparam int ST_FUSE  = 3;
	localparam int ST_LOCK  = 4;
	localparam int ST_PAR   = 7;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_WIPE  = 2'b11
	} cfp_state_type;

	typedef struct packed {
		logic        prog_reset;
		logic        store_n;
		logic        hv;
		logic        strobe_n;
		logic        sck;
		logic        mosi;
		logic [3:0]  mode;
		logic [13:0] addr;
		logic [7:0]  data;
	} cfp_pins_type;

	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
	} cfp_instr_type;

	function automatic logic cfp_in_range(input logic [13:0] a);
		return (a >= ADDR_LO) && (a <= ADDR_HI);
	endfunction
endpackage

// file: hw/cfp_code_mem.sv
// cfp_code_mem: 12K x 8 code array with registered read
// assumes one writer; write data passes through to the read port
`timescale 1ns/10ps
module cfp_code_mem (
	// clock
	input  wire logic       clk_i,
	// access
	input  wire logic       we_i,
	input  wire logic [13:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem [int'(cfp_pkg::DEPTH)];

	// shipped erased
	initial begin
		for (int i = 0; i < int'(cfp_pkg::DEPTH); i++) begin
			mem[i] = cfp_pkg::ERASED;
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i && addr_i < cfp_pkg::DEPTH) begin
			mem[addr_i] <= wdata_i;
		end
		// write-through so polling sees new data at once
		if (we_i) begin
			rdata_o <= wdata_i;
		end else if (addr_i < cfp_pkg::DEPTH) begin
			rdata_o <= mem[addr_i];
		end else begin
			rdata_o <= cfp_pkg::BLANK_RD;
		end
	end
endmodule

// file: sim/cfp_prog_model.sv
// cfp_prog_model: serial download host, drives sck and mosi
// assumes the bench calls xfer; clk_i is the port's core clock
`timescale 1ns/10ps
module cfp_prog_model (
	// clock
	input  wire logic clk_i,
	// serial link
	input  wire logic miso_i,
	output logic      sck_o,
	output logic      mosi_o
);
	initial begin
		sck_o  = 1'b0;
		mosi_o = 1'b0;
	end
	// 16 core cycles a bit: 80 ns, sck stands low between frames
	task automatic xfer(input logic [23:0] v, output logic [7:0] r);
		for (int i = 23; i >= 0; i--) begin
			mosi_o <= v[i];
			repeat (8) @(posedge clk_i);
			sck_o <= 1'b1;
			if (i < 8)
				r[i] = miso_i;
			repeat (8) @(posedge clk_i);
			sck_o <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
		mosi_o <= ~mosi_o; // released line never holds its last bit
		@(posedge clk_i);
	endtask
endmodule

// file: sim/code_flash_programming_port_bench.sv
// code_flash_programming_port_bench: self-checking bench of cfp_flash_port
// assumes cfp_prog_model as serial host; the bench is the parallel one
`timescale 1ns/10ps
module code_flash_programming_port_bench;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, we = 1'b0, prog = 1'b1, st_n = 1'b1, strb = 1'b1;
	logic [7:0]  adr = 8'h00, dpi = 8'h00, dpo, r;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [3:0]  mode = 4'h0;
	logic [13:0] addr = 14'h0;
	logic        ack, oe, pin, sck, mosi, miso;
	logic        hv = 1'b1;
	int          fails = 0, samples_checked = 0, cycles = 0, n;
	always #2.5 clk_i = ~clk_i;
	cfp_flash_port #(.PWRITE_CYC(50), .SWRITE_CYC(60), .SERASE_CYC(20000),
		.PULSE_CYC(40)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .prog_reset_i(prog),
		.store_enable_pin_n_i(st_n), .high_voltage_enable_pin_i(hv),
		.write_strobe_n_i(strb), .mode_select_a_i(mode[3]),
		.mode_select_b_i(mode[2]), .mode_select_c_i(mode[1]),
		.mode_select_d_i(mode[0]), .addr_i(addr), .data_port_i(dpi),
		.data_port_o(dpo), .data_port_oe_o(oe),
		.progress_indicator_pin_o(pin), .sck_i(sck), .mosi_i(mosi),
		.miso_o(miso));
	cfp_prog_model u_prog (.clk_i(clk_i), .miso_i(miso), .sck_o(sck),
		.mosi_o(mosi));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			fails++;
			test_done();
		end
	end
	// ****************************************************************
	// bus and pin tasks
	// ****************************************************************
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask
	task automatic idle();
		do wb(1'b0, cfp_pkg::REG_STATUS, 32'h0); while (q[0] !== 1'b0);
	endtask
	function automatic logic [23:0] ins(input logic [1:0] op,
		input logic [13:0] a, input logic [7:0] d);
		return {a[13:8], op, a[7:0], d};
	endfunction
	task automatic par(input logic [3:0] m, input logic [13:0] a,
		input logic [7:0] d);
		@(posedge clk_i);
		mode <= m;
		addr <= a;
		dpi <= d;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic pulse(input int len);
		strb <= 1'b0;
		repeat (len) @(posedge clk_i);
		strb <= 1'b1;
	endtask
	task automatic prd(input logic [3:0] m, input logic [13:0] a,
		input logic [7:0] e);
		par(m, a, ~e);
		chk({oe, dpo}, {1'b1, e});
	endtask
	task automatic pwrite(input logic [13:0] a, input logic [7:0] d);
		par(cfp_pkg::MODE_WRITE, a, d);
		pulse(10);
		for (n = 0; pin !== 1'b0 && n < 10; n++)
			@(posedge clk_i);
		chk(n < 10, 1'b1);
		par(cfp_pkg::MODE_READ, a, ~d);
		chk(dpo, {~d[7], d[6:0]});
		for (n = 9; pin === 1'b0 && n < 99; n++)
			@(posedge clk_i);
		chk(n >= 45 && n <= 55, 1'b1);
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs();
		wb(1'b0, cfp_pkg::REG_CTRL, 32'h0);
		chk(q[0], cfp_pkg::CTRL_RST);
		wb(1'b1, cfp_pkg::REG_CTRL, 32'h0);
		wb(1'b0, cfp_pkg::REG_CTRL, 32'h0);
		chk(q[0], 1'b0);
		wb(1'b1, cfp_pkg::REG_CTRL, 32'h1);
		wb(1'b1, 8'h40, 32'hffffffff);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		$display("registers done");
	endtask
	task automatic t_serial();
		u_prog.xfer({cfp_pkg::SER_KEY, 8'hfc, 8'h00}, r);
		wb(1'b0, cfp_pkg::REG_STATUS, 32'h0);
		chk(q[1], 1'b0);
		u_prog.xfer({cfp_pkg::SER_KEY, cfp_pkg::SER_ENABLE, 8'h00}, r);
		wb(1'b0, cfp_pkg::REG_STATUS, 32'h0);
		chk(q[2], 1'b1);
		for (int i = 0; i < 2; i++) begin
			u_prog.xfer(ins(cfp_pkg::OP_WRITE, 14'h2fff, 8'h3c ^ {8{i[0]}}), r);
			idle();
			u_prog.xfer(ins(cfp_pkg::OP_READ, 14'h2fff, 8'h00), r);
			chk(r, 8'h3c ^ {8{i[0]}});
		end
		u_prog.xfer({cfp_pkg::SER_KEY, 8'hfc, 8'h00}, r);
		u_prog.xfer(ins(cfp_pkg::OP_READ, 14'h0100, 8'h00), r);
		chk(r, 8'h00);
		idle();
		u_prog.xfer(ins(cfp_pkg::OP_READ, 14'h2fff, 8'h00), r);
		chk(r, 8'hff);
		$display("serial done");
	endtask
	task automatic t_parallel();
		st_n <= 1'b0;
		hv <= 1'b0;
		par(cfp_pkg::MODE_READ, 14'h0005, 8'h00);
		chk(oe, 1'b0);
		hv <= 1'b1;
		prd(cfp_pkg::MODE_RFUSE, 14'h0, 8'h00);
		pwrite(14'h0005, 8'h5a);
		prd(cfp_pkg::MODE_READ, 14'h0005, 8'h5a);
		pwrite(14'h0005, 8'h0f);
		prd(cfp_pkg::MODE_READ, 14'h0005, 8'h0a);
		wb(1'b0, cfp_pkg::REG_LAST, 32'h0);
		chk(q, 32'h00000005);
		prd(cfp_pkg::MODE_SIG, cfp_pkg::SIG0_ADR, 8'h5a);
		prd(cfp_pkg::MODE_SIG, cfp_pkg::SIG1_ADR, 8'ha5);
		par(cfp_pkg::MODE_WLOCK, 14'h0, 8'h7f);
		pulse(10);
		repeat (100) @(posedge clk_i);
		prd(cfp_pkg::MODE_RLOCK, 14'h0, 8'h04);
		prd(cfp_pkg::MODE_READ, 14'h0005, 8'h00);
		st_n <= 1'b1;
		u_prog.xfer({cfp_pkg::SER_KEY, cfp_pkg::SER_ENABLE, 8'h00}, r);
		u_prog.xfer(ins(cfp_pkg::OP_READ, 14'h0005, 8'h00), r);
		chk(r, 8'h00);
		st_n <= 1'b0;
		par(cfp_pkg::MODE_ERASE, 14'h0, 8'h00);
		pulse(50);
		idle();
		prd(cfp_pkg::MODE_RLOCK, 14'h0, 8'h00);
		prd(cfp_pkg::MODE_READ, 14'h0005, 8'hff);
		par(cfp_pkg::MODE_FUSE, 14'h0, 8'h01);
		pulse(50);
		prd(cfp_pkg::MODE_RFUSE, 14'h0, 8'h01);
		st_n <= 1'b1;
		u_prog.xfer(ins(cfp_pkg::OP_READ, 14'h0005, 8'h00), r);
		chk(r, 8'h00);
		prog <= 1'b0;
		repeat (10) @(posedge clk_i);
		wb(1'b0, cfp_pkg::REG_STATUS, 32'h0);
		chk(q & 32'h84, 32'h0);
		$display("parallel done");
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2000) @(posedge clk_i); // settle time, shortened
		t_regs();
		t_serial();
		t_parallel();
		test_done();
	end
endmodule
